// ### hw/npa_consts.vh
// constants and cadences for the network panel annunciator
// ****************************************************************************
// ****************************************************************************
`ifndef NPA_CONSTS_VH
`define NPA_CONSTS_VH
`define NPA_CLK_MHZ 250
`define NPA_FLASH_MS 500
`define NPA_ALARM_BEEP_MS 250
`define NPA_FAST_BEEP_MS 60
`define NPA_FAST_BEEPS 4
`define NPA_PAUSE_MS 480
`define NPA_SLOW_ON_MS 1000
`define NPA_SLOW_OFF_MS 2000
`define NPA_LONG_BEEP_MS 500
`define NPA_SHORT_BEEP_MS 50
`define NPA_REPLY_MS 5000
`define NPA_MS_CYC (`NPA_CLK_MHZ * 1000)
// tone codes
`define NPA_TONE_OFF 3'h0
`define NPA_TONE_FAULT 3'h1
`define NPA_TONE_ERROR 3'h2
`define NPA_TONE_ACCEPT 3'h3
`define NPA_TONE_ALARM 3'h4
`define NPA_TONE_TEST 3'h5
`define NPA_TONE_PANEL 3'h6
// command status codes
`define NPA_CMD_IDLE 3'h0
`define NPA_CMD_SENT 3'h1
`define NPA_CMD_NOT_SENT 3'h2
`define NPA_CMD_ACCEPTED 3'h3
`define NPA_CMD_NOT_ACCEPTED 3'h4
`define NPA_CMD_NOT_ACKD 3'h5
`endif

// ### hw/npa_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module npa_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// pins
	input wire [W-1:0] pin_in,
	// synchronised level
	output reg [W-1:0] level_out
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// s1 only feeds s2; level changes when s2 and s3 agree
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			level_out <= {W{1'b0}};
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
		end
	end
endmodule

// ### hw/npa_annunciator.v
// annunciator lamps, buzzer, command status and exception display
`timescale 1ns/100ps
`include "npa_consts.vh"
module npa_annunciator #(
	parameter integer FLASH_CYC = `NPA_FLASH_MS * `NPA_MS_CYC,
	parameter integer ALARM_BEEP_CYC = `NPA_ALARM_BEEP_MS * `NPA_MS_CYC,
	parameter integer FAST_BEEP_CYC = `NPA_FAST_BEEP_MS * `NPA_MS_CYC,
	parameter integer PAUSE_CYC = `NPA_PAUSE_MS * `NPA_MS_CYC,
	parameter integer SLOW_ON_CYC = `NPA_SLOW_ON_MS * `NPA_MS_CYC,
	parameter integer SLOW_OFF_CYC = `NPA_SLOW_OFF_MS * `NPA_MS_CYC,
	parameter integer LONG_BEEP_CYC = `NPA_LONG_BEEP_MS * `NPA_MS_CYC,
	parameter integer SHORT_BEEP_CYC = `NPA_SHORT_BEEP_MS * `NPA_MS_CYC,
	parameter integer REPLY_CYC = `NPA_REPLY_MS * `NPA_MS_CYC,
	parameter integer NPRIO = 4,
	parameter integer MSGW = 128
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// alarm list and local zone state
	input wire list_nonempty,
	input wire list_unacked,
	input wire list_new_alarm,
	input wire local_unacked_alarm,
	input wire local_zone_alarm,
	input wire local_unisolated_alarm,
	input wire local_new_brigade_alarm,
	input wire alarm_total_nz,
	// faults and isolates
	input wire fault_total_nz,
	input wire local_zone_fault,
	input wire local_fault_event,
	input wire system_fault_event,
	input wire remote_listed_fault_event,
	input wire local_unisolated_fault,
	input wire remote_permitted_fault,
	input wire isolate_total_nz,
	input wire local_point_isolated,
	input wire remote_point_isolated,
	input wire local_test_failed,
	input wire panel_fault,
	input wire remote_standby,
	// configuration
	input wire cfg_show_net_totals,
	input wire cfg_combined_brigade_alarm,
	input wire cfg_silence_on_reset,
	input wire cfg_silence_on_list_cmd,
	input wire cfg_silence_on_any_cmd,
	input wire [NPRIO-1:0] cfg_prio_enable,
	// key pin and list facility are asynchronous, beep requests are pulses
	input wire key_pin,
	input wire key_error,
	input wire key_accept,
	input wire alarm_list_facility,
	// network events, one-cycle pulses
	input wire net_fault_reset_rx,
	input wire net_list_cmd_rx,
	input wire net_any_cmd_rx,
	input wire cmd_issue,
	input wire cmd_queue_ok,
	input wire reply_accepted,
	input wire reply_rejected,
	input wire exc_valid,
	input wire [$clog2(NPRIO)-1:0] exc_prio,
	input wire [7:0] exc_panel_identifier,
	input wire [MSGW-1:0] exc_msg,
	// indicators
	output reg alarm_lamp,
	output reg fault_lamp,
	output reg isolated_lamp,
	output reg system_fault_lamp,
	output reg fault_relay,
	output reg buzzer,
	output reg [2:0] tone,
	// displays
	output reg [2:0] cmd_status,
	output reg exc_showing,
	output reg [7:0] exc_panel_out,
	output reg [MSGW-1:0] exc_msg_out,
	output reg key_seen
);
	// ************************************************************************
	// keypad synchronisation
	// ************************************************************************
	wire key_lvl;
	reg key_lvl_r;
	wire key_press;

	npa_sync #(.W(1)) u_key_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pin_in(key_pin),
		.level_out(key_lvl)
	);

	assign key_press = key_lvl & ~key_lvl_r;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			key_lvl_r <= 1'b0;
			key_seen <= 1'b0;
		end else begin
			key_lvl_r <= key_lvl;
			key_seen <= key_press;
		end
	end

	// ************************************************************************
	// common flash cadence
	// ************************************************************************
	reg [31:0] flash_cnt_r;
	reg flash_ph_r;

	// one shared phase so the alarm and isolated lamps blink in step
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt_r <= 32'h0;
			flash_ph_r <= 1'b0;
		end else if (flash_cnt_r >= FLASH_CYC - 1) begin
			flash_cnt_r <= 32'h0;
			flash_ph_r <= ~flash_ph_r;
		end else begin
			flash_cnt_r <= flash_cnt_r + 32'h1;
		end
	end

	// ************************************************************************
	// lamps
	// ************************************************************************
	wire alarm_flash = list_unacked | local_unacked_alarm;
	wire alarm_steady = (list_nonempty & ~list_unacked) | alarm_total_nz
		| local_zone_alarm;
	wire iso_flash = local_point_isolated
		| (remote_point_isolated & cfg_combined_brigade_alarm);
	wire sys_fault = system_fault_event | remote_standby;

	// flashing takes precedence over steady for both lamps
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alarm_lamp <= 1'b0;
			fault_lamp <= 1'b0;
			isolated_lamp <= 1'b0;
			system_fault_lamp <= 1'b0;
			fault_relay <= 1'b0;
		end else begin
			alarm_lamp <= alarm_flash ? flash_ph_r : alarm_steady;
			fault_lamp <= fault_total_nz | local_zone_fault;
			isolated_lamp <= iso_flash ? flash_ph_r : isolate_total_nz;
			system_fault_lamp <= sys_fault;
			fault_relay <= sys_fault | fault_total_nz | local_zone_fault;
		end
	end

	// ************************************************************************
	// buzzer requests
	// ************************************************************************
	reg fault_req_r;
	reg alarm_req_r;
	reg test_req_r;
	reg panel_req_r;
	reg panel_fault_r;
	wire silence = key_press
		| (cfg_silence_on_reset & net_fault_reset_rx)
		| (cfg_silence_on_list_cmd & net_list_cmd_rx)
		| (cfg_silence_on_any_cmd & (net_any_cmd_rx | net_list_cmd_rx
		| net_fault_reset_rx));
	wire fault_set = local_fault_event | sys_fault
		| (remote_listed_fault_event & cfg_show_net_totals);
	wire alarm_set = list_new_alarm | local_new_brigade_alarm;
	wire fault_gone = ~local_unisolated_fault & ~remote_permitted_fault & ~sys_fault;

	// new events win over a silence in the same cycle
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fault_req_r <= 1'b0;
			alarm_req_r <= 1'b0;
			test_req_r <= 1'b0;
			panel_req_r <= 1'b0;
			panel_fault_r <= 1'b0;
		end else begin
			if (fault_set)
				fault_req_r <= 1'b1;
			else if (silence | fault_gone)
				fault_req_r <= 1'b0;
			if (alarm_set)
				alarm_req_r <= 1'b1;
			else if (silence | (~list_nonempty & ~local_unisolated_alarm))
				alarm_req_r <= 1'b0;
			if (local_test_failed)
				test_req_r <= 1'b1;
			else if (silence)
				test_req_r <= 1'b0;
			// a key holds the slow tone off until the panel fault rises afresh
			panel_fault_r <= panel_fault;
			if (panel_fault & ~panel_fault_r)
				panel_req_r <= 1'b1;
			else if (silence | ~panel_fault)
				panel_req_r <= 1'b0;
		end
	end

	// ************************************************************************
	// one-shot beeps and tone selection
	// ************************************************************************
	reg [31:0] beep_cnt_r;
	reg [2:0] shot_r;
	reg [2:0] tone_nxt;

	// error and accept beeps run a fixed length, a key cancels nothing here
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			beep_cnt_r <= 32'h0;
			shot_r <= `NPA_TONE_OFF;
		end else if (key_error) begin
			beep_cnt_r <= LONG_BEEP_CYC;
			shot_r <= `NPA_TONE_ERROR;
		end else if (key_accept) begin
			beep_cnt_r <= SHORT_BEEP_CYC;
			shot_r <= `NPA_TONE_ACCEPT;
		end else if (beep_cnt_r != 32'h0) begin
			beep_cnt_r <= beep_cnt_r - 32'h1;
		end else begin
			shot_r <= `NPA_TONE_OFF;
		end
	end

	// fixed priority among active requests
	always @* begin
		if (fault_req_r)
			tone_nxt = `NPA_TONE_FAULT;
		else if (shot_r != `NPA_TONE_OFF)
			tone_nxt = shot_r;
		else if (alarm_req_r)
			tone_nxt = `NPA_TONE_ALARM;
		else if (test_req_r)
			tone_nxt = `NPA_TONE_TEST;
		else if (panel_req_r)
			tone_nxt = `NPA_TONE_PANEL;
		else
			tone_nxt = `NPA_TONE_OFF;
	end

	// ************************************************************************
	// cadence generator
	// ************************************************************************
	reg [31:0] cad_cnt_r;
	reg [3:0] cad_step_r;
	reg [2:0] tone_r;

	// restart cadence whenever the selected tone changes
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cad_cnt_r <= 32'h0;
			cad_step_r <= 4'h0;
			tone_r <= `NPA_TONE_OFF;
			tone <= `NPA_TONE_OFF;
			buzzer <= 1'b0;
		end else begin
			tone_r <= tone_nxt;
			tone <= tone_nxt;
			if (tone_nxt != tone_r) begin
				cad_cnt_r <= 32'h0;
				cad_step_r <= 4'h0;
				buzzer <= 1'b0;
			end else begin
				case (tone_r)
				`NPA_TONE_FAULT, `NPA_TONE_ERROR, `NPA_TONE_ACCEPT: begin
					buzzer <= 1'b1;
				end
				`NPA_TONE_ALARM: begin
					// 250 ms on, 250 ms off gives two beeps per second
					buzzer <= ~cad_step_r[0];
					if (cad_cnt_r >= ALARM_BEEP_CYC - 1) begin
						cad_cnt_r <= 32'h0;
						cad_step_r <= {3'h0, ~cad_step_r[0]};
					end else begin
						cad_cnt_r <= cad_cnt_r + 32'h1;
					end
				end
				`NPA_TONE_TEST: begin
					// steps 0..7 are four on/off pairs, step 8 is the pause
					buzzer <= (cad_step_r < 2 * `NPA_FAST_BEEPS) & ~cad_step_r[0];
					if (cad_cnt_r >= ((cad_step_r == 2 * `NPA_FAST_BEEPS) ?
						PAUSE_CYC : FAST_BEEP_CYC) - 1) begin
						cad_cnt_r <= 32'h0;
						cad_step_r <= (cad_step_r == 2 * `NPA_FAST_BEEPS) ? 4'h0 :
							cad_step_r + 4'h1;
					end else begin
						cad_cnt_r <= cad_cnt_r + 32'h1;
					end
				end
				`NPA_TONE_PANEL: begin
					buzzer <= ~cad_step_r[0];
					if (cad_cnt_r >= (cad_step_r[0] ? SLOW_OFF_CYC : SLOW_ON_CYC) - 1) begin
						cad_cnt_r <= 32'h0;
						cad_step_r <= {3'h0, ~cad_step_r[0]};
					end else begin
						cad_cnt_r <= cad_cnt_r + 32'h1;
					end
				end
				default: begin
					buzzer <= 1'b0;
				end
				endcase
			end
		end
	end

	// ************************************************************************
	// network command status
	// ************************************************************************
	reg [31:0] reply_cnt_r;

	// an issue while sent is ignored, so a reply or timeout in that cycle still lands
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_status <= `NPA_CMD_IDLE;
			reply_cnt_r <= 32'h0;
		end else if (cmd_issue & (cmd_status != `NPA_CMD_SENT)) begin
			if (cmd_queue_ok) begin
				cmd_status <= `NPA_CMD_SENT;
				reply_cnt_r <= 32'h0;
			end else begin
				cmd_status <= `NPA_CMD_NOT_SENT;
			end
		end else if (cmd_status == `NPA_CMD_SENT) begin
			if (reply_accepted)
				cmd_status <= `NPA_CMD_ACCEPTED;
			else if (reply_rejected)
				cmd_status <= `NPA_CMD_NOT_ACCEPTED;
			else if (reply_cnt_r >= REPLY_CYC - 1)
				cmd_status <= `NPA_CMD_NOT_ACKD;
			else
				reply_cnt_r <= reply_cnt_r + 32'h1;
		end
	end

	// ************************************************************************
	// exception display
	// ************************************************************************
	wire list_lvl;
	wire exc_ok = exc_valid & cfg_prio_enable[exc_prio];

	npa_sync #(.W(1)) u_list_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pin_in(alarm_list_facility),
		.level_out(list_lvl)
	);

	// the host display resumes when exc_showing falls; searches are untouched
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exc_showing <= 1'b0;
			exc_panel_out <= 8'h00;
			exc_msg_out <= {MSGW{1'b0}};
		end else if (exc_showing) begin
			if (list_lvl | key_press)
				exc_showing <= 1'b0;
		end else if (exc_ok & ~list_lvl) begin
			// new arrivals while showing are ignored above
			exc_showing <= 1'b1;
			exc_panel_out <= exc_panel_identifier;
			exc_msg_out <= exc_msg;
		end
	end
endmodule

// ### test/npa_checker.sv
// concurrent checks on the annunciator ports
`timescale 1ns/100ps
`include "npa_consts.vh"
// ****************************************************************
// port checker
// ****************************************************************
module npa_checker #(
	parameter integer NPRIO = 4,
	parameter integer MSGW = 128,
	parameter integer REPLY_CYC = 20
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// level inputs
	input wire fault_total_nz,
	input wire local_zone_fault,
	input wire isolate_total_nz,
	input wire local_point_isolated,
	input wire remote_point_isolated,
	input wire cfg_combined_brigade_alarm,
	input wire [NPRIO-1:0] cfg_prio_enable,
	// event inputs
	input wire cmd_issue,
	input wire cmd_queue_ok,
	input wire reply_accepted,
	input wire reply_rejected,
	input wire exc_valid,
	input wire [$clog2(NPRIO)-1:0] exc_prio,
	// outputs
	input wire fault_lamp,
	input wire isolated_lamp,
	input wire [2:0] cmd_status,
	input wire exc_showing,
	input wire [MSGW-1:0] exc_msg_out,
	input wire key_seen
);
	// slack covers the registers on entry to and exit from sent
	localparam int RLIM = REPLY_CYC + 4;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// lamps, one cycle behind their causes
	a_fault_lamp_follows: assert property ($past(rst_n)
		|-> fault_lamp == ($past(fault_total_nz) || $past(local_zone_fault)))
		else $error("fault lamp does not follow its causes");
	a_isolated_steady: assert property ($past(rst_n) && !$past(local_point_isolated)
		&& !($past(remote_point_isolated) && $past(cfg_combined_brigade_alarm))
		|-> isolated_lamp == $past(isolate_total_nz)) else $error("isolated lamp not steady");
	// command status
	a_cmd_sent: assert property (cmd_issue && cmd_queue_ok
		&& cmd_status != `NPA_CMD_SENT |=> cmd_status == `NPA_CMD_SENT)
		else $error("queued command not shown as sent");
	a_cmd_not_sent: assert property (cmd_issue && !cmd_queue_ok
		&& cmd_status != `NPA_CMD_SENT |=> cmd_status == `NPA_CMD_NOT_SENT)
		else $error("unqueued command not shown as not sent");
	a_reply_shown: assert property (cmd_status == `NPA_CMD_SENT
		&& (reply_accepted || reply_rejected) |=> cmd_status == ($past(reply_accepted)
		? `NPA_CMD_ACCEPTED : `NPA_CMD_NOT_ACCEPTED)) else $error("reply code not shown");
	a_reply_wait_bound: assert property ($rose(cmd_status == `NPA_CMD_SENT)
		|-> ##[1:RLIM] cmd_status != `NPA_CMD_SENT) else $error("sent status outlives limit");
	a_timeout_code: assert property ($past(rst_n) && $past(cmd_status) == `NPA_CMD_SENT
		&& cmd_status != `NPA_CMD_SENT && !$past(reply_accepted) && !$past(reply_rejected)
		|-> cmd_status == `NPA_CMD_NOT_ACKD) else $error("silent peer not shown as not acked");
	// exception display
	a_exc_ignored: assert property (exc_valid && !cfg_prio_enable[exc_prio]
		&& !exc_showing |=> !exc_showing) else $error("disabled priority exception shown");
	a_exc_discard: assert property (exc_showing && exc_valid
		|=> $stable(exc_msg_out)) else $error("exception replaced while shown");
	a_key_clears: assert property (key_seen && $past(exc_showing)
		|-> !exc_showing) else $error("key press left exception shown");
endmodule
bind npa_annunciator npa_checker #(.NPRIO(NPRIO), .MSGW(MSGW), .REPLY_CYC(REPLY_CYC)) chk (.*);

// ### test/npa_peer.sv
// model of a peer panel answering network commands
`timescale 1ns/100ps
// ****************************************************************
// peer panel
// ****************************************************************
module npa_peer (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// command from the local panel
	input wire cmd_issue,
	input wire cmd_queue_ok,
	// answer kind (0 accept, 1 reject, 2 silent) and delay
	input wire [1:0] peer_mode,
	input wire [7:0] peer_delay,
	// replies, one-cycle pulses
	output reg reply_accepted,
	output reg reply_rejected
);
	reg busy_r;
	reg [7:0] wait_r;
	// silent mode stands in for a busy or off-line panel
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			wait_r <= 8'h00;
			reply_accepted <= 1'b0;
			reply_rejected <= 1'b0;
		end else begin
			reply_accepted <= 1'b0;
			reply_rejected <= 1'b0;
			if (!busy_r && cmd_issue && cmd_queue_ok) begin
				busy_r <= 1'b1;
				wait_r <= peer_delay;
			end else if (busy_r && wait_r != 8'h00) begin
				wait_r <= wait_r - 8'h01;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				reply_accepted <= (peer_mode == 2'h0);
				reply_rejected <= (peer_mode == 2'h1);
			end
		end
	end
endmodule

// ### test/testbench.sv
// self-checking bench for the annunciator
`timescale 1ns/100ps
`include "npa_consts.vh"
// ****************************************************************
// testbench
// ****************************************************************
module testbench;
	localparam integer FL = 8;
	localparam integer AB = 6;
	localparam integer FB = 3;
	localparam integer PS = 10;
	localparam integer RC = 20;
	localparam integer SN = 4;
	localparam integer LB = 8;
	localparam integer SB = 4;
	reg clock;
	reg rst_n = 1'b0;
	reg [13:0] lv = 14'h0000;
	reg [9:0] pv = 10'h000;
	reg [4:0] cv = 5'h00;
	reg panel_fault = 1'b0;
	reg remote_permitted_fault = 1'b0;
	reg key_pin = 1'b0;
	reg alarm_list_facility = 1'b0;
	reg cmd_issue = 1'b0;
	reg cmd_queue_ok = 1'b0;
	reg exc_valid = 1'b0;
	reg [3:0] cfg_prio_enable = 4'h0;
	reg [1:0] exc_prio = 2'h0;
	reg [1:0] peer_mode = 2'h0;
	reg [7:0] exc_panel_identifier = 8'h00;
	reg [7:0] peer_delay = 8'h00;
	reg [127:0] exc_msg = 128'h0;
	wire reply_accepted, reply_rejected, alarm_lamp, fault_lamp, isolated_lamp;
	wire system_fault_lamp, fault_relay, buzzer, exc_showing, key_seen;
	wire [2:0] tone, cmd_status;
	wire [7:0] exc_panel_out;
	wire [127:0] exc_msg_out;
	wire [2:0] lamps = {isolated_lamp, fault_lamp, alarm_lamp};
	integer fail_count = 0;
	integer check_count = 0;
	// short cadences keep the run brief
	npa_annunciator #(.FLASH_CYC(FL), .ALARM_BEEP_CYC(AB), .FAST_BEEP_CYC(FB), .PAUSE_CYC(PS),
		.SLOW_ON_CYC(SN), .SLOW_OFF_CYC(2 * SN), .LONG_BEEP_CYC(LB), .SHORT_BEEP_CYC(SB),
		.REPLY_CYC(RC)) dut (.list_unacked(lv[0]), .local_unacked_alarm(lv[1]),
		.list_nonempty(lv[2]), .alarm_total_nz(lv[3]), .local_zone_alarm(lv[4]),
		.fault_total_nz(lv[5]), .local_zone_fault(lv[6]), .isolate_total_nz(lv[7]),
		.local_point_isolated(lv[8]), .remote_point_isolated(lv[9]),
		.local_unisolated_alarm(lv[10]), .local_unisolated_fault(lv[11]),
		.remote_standby(lv[12]), .system_fault_event(lv[13]), .list_new_alarm(pv[0]),
		.local_new_brigade_alarm(pv[1]), .local_fault_event(pv[2]),
		.remote_listed_fault_event(pv[3]), .local_test_failed(pv[4]), .key_error(pv[5]),
		.key_accept(pv[6]), .net_fault_reset_rx(pv[7]), .net_list_cmd_rx(pv[8]),
		.net_any_cmd_rx(pv[9]), .cfg_show_net_totals(cv[0]),
		.cfg_combined_brigade_alarm(cv[1]), .cfg_silence_on_reset(cv[2]),
		.cfg_silence_on_list_cmd(cv[3]), .cfg_silence_on_any_cmd(cv[4]), .*);
	npa_peer peer (.*);
	// 250 MHz clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task tick(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task check(input [136:0] got, input [136:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task pulse(input integer b);
		pv[b] = 1'b1;
		tick(1);
		pv[b] = 1'b0;
		tick(1);
	endtask
	// bounded wait on tone (sel 0) or command status (sel 1)
	task wait_val(input integer sel, input [2:0] v, input integer lim);
		integer i;
		for (i = 0; i < lim && (sel ? cmd_status : tone) !== v; i = i + 1)
			tick(1);
		check(sel ? cmd_status : tone, v);
	endtask
	task press;
		key_pin = 1'b1;
		tick(6);
		key_pin = 1'b0;
		tick(6);
	endtask
	// saw bit 1 means lamp seen on, bit 0 seen off
	task lamp_case(input integer b, input c, input integer l, input [1:0] e);
		integer i;
		reg [1:0] saw;
		lv[b] = 1'b1;
		cv[1] = c;
		saw = 2'b00;
		tick(2);
		for (i = 0; i < 2 * FL + 4; i = i + 1) begin
			saw = saw | ((lamps[l] === 1'b1) ? 2'b10 : 2'b01);
			tick(1);
		end
		check(saw, e);
		lv[b] = 1'b0;
		cv[1] = 1'b0;
		tick(2);
	endtask
	task count_rise(input integer n, input integer e);
		integer i, r;
		reg last;
		r = 0;
		last = buzzer;
		for (i = 0; i < n; i = i + 1) begin
			tick(1);
			if (buzzer === 1'b1 && last !== 1'b1)
				r = r + 1;
			last = buzzer;
		end
		check(r, e);
	endtask
	task t_lamps;
		lamp_case(0, 0, 0, 2'b11);
		lamp_case(1, 0, 0, 2'b11);
		lamp_case(2, 0, 0, 2'b10);
		lamp_case(3, 0, 0, 2'b10);
		lamp_case(4, 0, 0, 2'b10);
		lamp_case(5, 0, 1, 2'b10);
		lamp_case(6, 0, 1, 2'b10);
		lamp_case(7, 0, 2, 2'b10);
		lamp_case(8, 0, 2, 2'b11);
		lamp_case(9, 1, 2, 2'b11);
		lamp_case(9, 0, 2, 2'b01);
		lv = 14'h0101;
		tick(FL + 3);
		check(alarm_lamp, isolated_lamp);
		lv = 14'h0000;
	endtask
	task issue(input ok);
		cmd_issue = 1'b1;
		cmd_queue_ok = ok;
		tick(1);
		cmd_issue = 1'b0;
		tick(1);
	endtask
	task t_cmd;
		integer m;
		issue(1'b0);
		check(cmd_status, `NPA_CMD_NOT_SENT);
		for (m = 0; m < 3; m = m + 1) begin
			peer_mode = m[1:0];
			peer_delay = 3 + 8 * m;
			issue(1'b1);
			check(cmd_status, `NPA_CMD_SENT);
			issue(1'b1);
			check(cmd_status, `NPA_CMD_SENT);
			if (m == 2) begin
				tick(RC - 4);
				check(cmd_status, `NPA_CMD_SENT);
			end
			wait_val(1, m == 0 ? `NPA_CMD_ACCEPTED : m == 1 ? `NPA_CMD_NOT_ACCEPTED
				: `NPA_CMD_NOT_ACKD, RC + 8);
		end
	endtask
	task exc(input [1:0] p, input [7:0] id);
		exc_valid = 1'b1;
		exc_prio = p;
		exc_panel_identifier = id;
		exc_msg = {16{id}};
		tick(1);
		exc_valid = 1'b0;
		tick(1);
	endtask
	task t_exc;
		cfg_prio_enable = 4'h5;
		exc(2'h1, 8'h21);
		check(exc_showing, 1'b0);
		exc(2'h2, 8'h42);
		check({exc_showing, exc_panel_out, exc_msg_out}, {9'h142, {16{8'h42}}});
		exc(2'h0, 8'h63);
		check({exc_panel_out, exc_msg_out}, {8'h42, {16{8'h42}}});
		press;
		check(exc_showing, 1'b0);
		alarm_list_facility = 1'b1;
		tick(6);
		exc(2'h0, 8'h17);
		check(exc_showing, 1'b0);
		alarm_list_facility = 1'b0;
		tick(6);
		exc(2'h2, 8'h35);
		check(exc_showing, 1'b1);
		alarm_list_facility = 1'b1;
		tick(8);
		check(exc_showing, 1'b0);
		alarm_list_facility = 1'b0;
		tick(6);
	endtask
	task t_tones;
		integer k;
		for (k = 0; k < 2; k = k + 1) begin
			lv[2] = 1'b1;
			pulse(k);
			wait_val(0, `NPA_TONE_ALARM, 6);
			count_rise(4 * AB, 2);
			lv[2] = 1'b0;
			wait_val(0, `NPA_TONE_OFF, 6);
		end
		for (k = 0; k < 3; k = k + 1) begin
			lv[11] = 1'b1;
			lv[13] = (k == 1);
			cv[0] = 1'b1;
			if (k != 1)
				pulse(k == 0 ? 2 : 3);
			wait_val(0, `NPA_TONE_FAULT, 6);
			lv[11] = 1'b0;
			lv[13] = 1'b0;
			wait_val(0, `NPA_TONE_OFF, 6);
		end
		// a listed remote fault stays quiet while network totals are not shown
		cv[0] = 1'b0;
		lv[11] = 1'b1;
		pulse(3);
		tick(3);
		check(tone, `NPA_TONE_OFF);
		lv[2] = 1'b1;
		lv[11] = 1'b1;
		pulse(2);
		pulse(0);
		tick(4);
		check(tone, `NPA_TONE_FAULT);
		press;
		check({buzzer, tone}, {1'b0, `NPA_TONE_OFF});
		lv = 14'h1000;
		wait_val(0, `NPA_TONE_FAULT, 6);
		check({system_fault_lamp, fault_relay}, 2'b11);
		press;
		lv = 14'h0000;
		wait_val(0, `NPA_TONE_OFF, 6);
		cv = 5'h00;
		for (k = 0; k < 3; k = k + 1) begin
			lv[11] = 1'b1;
			pulse(2);
			pulse(7 + k);
			tick(3);
			check(tone, `NPA_TONE_FAULT);
			cv[2 + k] = 1'b1;
			pulse(7 + k);
			wait_val(0, `NPA_TONE_OFF, 6);
			cv[2 + k] = 1'b0;
			lv[11] = 1'b0;
		end
		pulse(4);
		wait_val(0, `NPA_TONE_TEST, 6);
		count_rise(2 * (8 * FB + PS), 8);
		press;
		check(buzzer, 1'b0);
		// slow panel tone, then key beeps over the alarm cadence
		panel_fault = 1'b1;
		wait_val(0, `NPA_TONE_PANEL, 6);
		count_rise(6 * SN, 2);
		press;
		check(tone, `NPA_TONE_OFF);
		lv[2] = 1'b1;
		pulse(0);
		pulse(6);
		wait_val(0, `NPA_TONE_ACCEPT, 6);
		wait_val(0, `NPA_TONE_ALARM, SB + 6);
		pulse(5);
		wait_val(0, `NPA_TONE_ERROR, 6);
		panel_fault = 1'b0;
		lv[2] = 1'b0;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		tick(12);
		rst_n = 1'b1;
		tick(2);
		t_lamps;
		t_cmd;
		t_exc;
		t_tones;
		stop_test;
	end
	// the sequence needs under two thousand cycles; allow five times that
	initial begin
		#40000;
		fail_count = fail_count + 1;
		stop_test;
	end
endmodule
